// >>> hdl/pwrc_idle_powerdown.v
// Idle and power-down mode controller with wake, reset-pin and internal reset sequencing
// Functional notes
// - Idle interrupt wake returns after idle instruction
// - Reset pin clears idle, restores clock, vector 0000h
// - Few instructions run before internal reset
// - RAM blocked, ports usable before internal reset
// - ADC completion ends converter-requested idle mode
// - Power-down stops oscillator, freezes all clocks
// - Power-down preserves PC, status, registers, RAM
// - Power-down bit enters mode immediately
// - Enabled external interrupt clears bit, restarts oscillator and peripheral clocks
// - External wake resumes when input released
// - Keyboard wake resumes after 1024 clocks
// - Power-down wake enters ISR, then next instruction
// - Interrupt wake leaves registers and RAM intact
// - Reset pin clears power-down bit, then reinitialises
// - Reset wake redefines registers, keeps RAM
`include "pwrc_regs.vh"

module pwrc_idle_powerdown #(
  parameter KBD_W = 8,
  parameter CNT_W = 11,
  parameter PC_W = 16,
  parameter [CNT_W-1:0] KBD_WAKE_CLKS = `PWRC_KBD_WAKE_CLKS,
  parameter [CNT_W-1:0] INT_RESET_CLKS = `PWRC_INT_RESET_CLKS,
  parameter [CNT_W-1:0] TAKEOVER_CLKS = `PWRC_TAKEOVER_CLKS
) (
  // Clock, reset and clock enable
  input wire clk_sys,
  input wire reset_n,
  input wire ce,
  // Reset pin, active high
  input wire rst_pin,
  // Register port
  input wire [`PWRC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  // Wake sources
  input wire irq_pending,
  input wire adc_done,
  input wire ext_irq_a_n,
  input wire ext_irq_a_en,
  input wire ext_irq_b_n,
  input wire ext_irq_b_en,
  input wire [KBD_W-1:0] keyboard_wake_inputs,
  input wire kbd_wake_en,
  // Core interface
  input wire [PC_W-1:0] core_next_pc,
  output reg cpu_clk_en_ff,
  output reg periph_clk_en_ff,
  output reg osc_en_ff,
  output reg ram_access_en_ff,
  output reg sfr_reset_ff,
  output reg wake_irq_ff,
  output reg resume_load_ff,
  output reg [PC_W-1:0] resume_addr_ff,
  // Mode bits
  output reg idle_request_bit_ff,
  output reg powerdown_request_bit_ff
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_PDOWN = 3'h2;
  localparam [2:0] ST_EXT_WAIT = 3'h3;
  localparam [2:0] ST_KBD_WAIT = 3'h4;
  localparam [2:0] ST_RST_RUN = 3'h5;
  localparam [2:0] ST_INT_RST = 3'h6;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire clr_n;
  wire cnt_zero;
  wire wr_power_control_reg;
  wire wr_cfg;
  wire ext_wake;
  wire ext_released;
  wire kbd_wake;
  wire idle_wake;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg user_flag_low_ff;
  reg user_flag_high_ff;
  reg adc_idle_ff;
  reg [PC_W-1:0] saved_pc_ff;
  reg [PC_W-1:0] nxt_saved_pc;
  reg nxt_idle;
  reg nxt_pdown;
  reg nxt_cpu_clk;
  reg nxt_periph_clk;
  reg nxt_osc;
  reg nxt_ram_access;
  reg nxt_sfr_reset;
  reg nxt_wake_irq;
  reg nxt_resume_load;
  reg [PC_W-1:0] nxt_resume_addr;
  reg cnt_load;
  reg [CNT_W-1:0] cnt_load_val;
  reg [7:0] nxt_rdata;
  localparam [7:0] RST_POWER_CONTROL_REG = `PWRC_RST_POWER_CONTROL;
  localparam [7:0] RST_CFG = `PWRC_RST_CONFIG;

  // Reset pin acts without the clock on the mode bits and clocks
  assign clr_n = reset_n & ~rst_pin;

  assign wr_power_control_reg = reg_wr && (reg_addr == `PWRC_OFS_POWER_CONTROL);
  assign wr_cfg = reg_wr && (reg_addr == `PWRC_OFS_CONFIG);

  assign ext_wake = (ext_irq_a_en & ~ext_irq_a_n) | (ext_irq_b_en & ~ext_irq_b_n);
  assign ext_released = ~(ext_irq_a_en & ~ext_irq_a_n) & ~(ext_irq_b_en & ~ext_irq_b_n);
  assign kbd_wake = kbd_wake_en & (|keyboard_wake_inputs);
  assign idle_wake = irq_pending | (adc_idle_ff & adc_done);

  // ****************************************************************
  // Delay counter
  // ****************************************************************
  pwrc_wait_cnt #(
    .W(CNT_W),
    .RST_VAL(TAKEOVER_CLKS)
  ) u_wait_cnt (
    .clk_sys(clk_sys),
    .clr_n(clr_n),
    .ce(ce),
    .load(cnt_load),
    .load_val(cnt_load_val),
    .zero(cnt_zero)
  );

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  always @* begin
    nxt_state = state_ff;
    nxt_idle = idle_request_bit_ff;
    nxt_pdown = powerdown_request_bit_ff;
    nxt_cpu_clk = cpu_clk_en_ff;
    nxt_periph_clk = periph_clk_en_ff;
    nxt_osc = osc_en_ff;
    nxt_ram_access = ram_access_en_ff;
    nxt_sfr_reset = 1'b0;
    nxt_wake_irq = 1'b0;
    nxt_resume_load = 1'b0;
    nxt_resume_addr = resume_addr_ff;
    nxt_saved_pc = saved_pc_ff;
    cnt_load = 1'b0;
    cnt_load_val = KBD_WAKE_CLKS;
    case (state_ff)
      ST_RUN: begin
        if (wr_power_control_reg && reg_wdata[`PWRC_BIT_POWERDOWN]) begin
          // Entry takes effect at the writing instruction
          nxt_pdown = 1'b1;
          nxt_idle = reg_wdata[`PWRC_BIT_IDLE];
          nxt_saved_pc = core_next_pc;
          nxt_osc = 1'b0;
          nxt_cpu_clk = 1'b0;
          nxt_periph_clk = 1'b0;
          nxt_state = ST_PDOWN;
        end else if (wr_power_control_reg && reg_wdata[`PWRC_BIT_IDLE]) begin
          nxt_idle = 1'b1;
          nxt_saved_pc = core_next_pc;
          nxt_cpu_clk = 1'b0;
          nxt_periph_clk = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (idle_wake) begin
          nxt_idle = 1'b0;
          nxt_cpu_clk = 1'b1;
          nxt_wake_irq = irq_pending;
          nxt_resume_load = 1'b1;
          nxt_resume_addr = saved_pc_ff;
          nxt_state = ST_RUN;
        end
      end
      ST_PDOWN: begin
        // Clocks stay frozen, so core state, registers and RAM hold
        if (ext_wake) begin
          nxt_pdown = 1'b0;
          nxt_osc = 1'b1;
          nxt_periph_clk = 1'b1;
          nxt_state = ST_EXT_WAIT;
        end else if (kbd_wake) begin
          nxt_pdown = 1'b0;
          nxt_osc = 1'b1;
          nxt_periph_clk = 1'b1;
          cnt_load = 1'b1;
          cnt_load_val = KBD_WAKE_CLKS;
          nxt_state = ST_KBD_WAIT;
        end
      end
      ST_EXT_WAIT: begin
        // No register reset on this path, contents stay intact
        if (ext_released) begin
          nxt_cpu_clk = 1'b1;
          nxt_wake_irq = 1'b1;
          nxt_resume_load = 1'b1;
          nxt_resume_addr = saved_pc_ff;
          nxt_state = ST_RUN;
        end
      end
      ST_KBD_WAIT: begin
        if (cnt_zero) begin
          nxt_cpu_clk = 1'b1;
          nxt_wake_irq = 1'b1;
          nxt_resume_load = 1'b1;
          nxt_resume_addr = saved_pc_ff;
          nxt_state = ST_RUN;
        end
      end
      ST_RST_RUN: begin
        // Core runs a few instructions with RAM blocked
        nxt_ram_access = 1'b0;
        if (cnt_zero) begin
          cnt_load = 1'b1;
          cnt_load_val = INT_RESET_CLKS;
          nxt_sfr_reset = 1'b1;
          nxt_state = ST_INT_RST;
        end
      end
      ST_INT_RST: begin
        nxt_sfr_reset = 1'b1;
        if (cnt_zero) begin
          nxt_sfr_reset = 1'b0;
          nxt_ram_access = 1'b1;
          nxt_resume_load = 1'b1;
          nxt_resume_addr = `PWRC_RESET_VECTOR;
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RST_RUN;
      end
    endcase
  end

  // ****************************************************************
  // Mode registers, cleared without clock by the reset pin
  // ****************************************************************
  always @(posedge clk_sys or negedge clr_n) begin
    if (!clr_n) begin
      state_ff <= ST_RST_RUN;
      idle_request_bit_ff <= 1'b0;
      powerdown_request_bit_ff <= 1'b0;
      cpu_clk_en_ff <= 1'b1;
      periph_clk_en_ff <= 1'b1;
      osc_en_ff <= 1'b1;
      ram_access_en_ff <= 1'b0;
      sfr_reset_ff <= 1'b0;
      wake_irq_ff <= 1'b0;
      resume_load_ff <= 1'b0;
      resume_addr_ff <= `PWRC_RESET_VECTOR;
    end else if (ce) begin
      state_ff <= nxt_state;
      idle_request_bit_ff <= nxt_idle;
      powerdown_request_bit_ff <= nxt_pdown;
      cpu_clk_en_ff <= nxt_cpu_clk;
      periph_clk_en_ff <= nxt_periph_clk;
      osc_en_ff <= nxt_osc;
      ram_access_en_ff <= nxt_ram_access;
      sfr_reset_ff <= nxt_sfr_reset;
      wake_irq_ff <= nxt_wake_irq;
      resume_load_ff <= nxt_resume_load;
      resume_addr_ff <= nxt_resume_addr;
    end
  end

  // ****************************************************************
  // Saved return address, kept through the internal reset
  // ****************************************************************
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      saved_pc_ff <= {PC_W{1'b0}};
    end else if (ce) begin
      saved_pc_ff <= nxt_saved_pc;
    end
  end

  // ****************************************************************
  // Software flags and configuration, redefined by internal reset
  // ****************************************************************
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      user_flag_low_ff <= RST_POWER_CONTROL_REG[`PWRC_BIT_FLAG_LOW];
      user_flag_high_ff <= RST_POWER_CONTROL_REG[`PWRC_BIT_FLAG_HIGH];
      adc_idle_ff <= RST_CFG[`PWRC_BIT_ADC_IDLE];
    end else if (ce) begin
      if (state_ff == ST_INT_RST) begin
        user_flag_low_ff <= 1'b0;
        user_flag_high_ff <= 1'b0;
        adc_idle_ff <= 1'b0;
      end else begin
        if (wr_power_control_reg) begin
          user_flag_low_ff <= reg_wdata[`PWRC_BIT_FLAG_LOW];
          user_flag_high_ff <= reg_wdata[`PWRC_BIT_FLAG_HIGH];
        end
        if (wr_cfg) begin
          adc_idle_ff <= reg_wdata[`PWRC_BIT_ADC_IDLE];
        end
      end
    end
  end

  // ****************************************************************
  // Read data, one cycle after the read strobe
  // ****************************************************************
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `PWRC_OFS_POWER_CONTROL) begin
        nxt_rdata[`PWRC_BIT_IDLE] = idle_request_bit_ff;
        nxt_rdata[`PWRC_BIT_POWERDOWN] = powerdown_request_bit_ff;
        nxt_rdata[`PWRC_BIT_FLAG_LOW] = user_flag_low_ff;
        nxt_rdata[`PWRC_BIT_FLAG_HIGH] = user_flag_high_ff;
      end else if (reg_addr == `PWRC_OFS_CONFIG) begin
        nxt_rdata[`PWRC_BIT_ADC_IDLE] = adc_idle_ff;
      end else if (reg_addr == `PWRC_OFS_STATUS) begin
        nxt_rdata[`PWRC_STAT_STATE_MSB:`PWRC_STAT_STATE_LSB] = state_ff;
        nxt_rdata[`PWRC_STAT_ADC_IDLE] = adc_idle_ff;
        nxt_rdata[`PWRC_STAT_RAM_OK] = ram_access_en_ff;
      end
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (ce) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule // pwrc_idle_powerdown

// >>> hdl/pwrc_regs.vh
// Register offsets, field positions, reset values and counts of the power-mode controller
`ifndef PWRC_REGS_VH
`define PWRC_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PWRC_ADDR_W 8
`define PWRC_OFS_POWER_CONTROL 8'h00
`define PWRC_OFS_CONFIG 8'h04
`define PWRC_OFS_STATUS 8'h08

// ****************************************************************
// Field positions of power_control_reg
// ****************************************************************
`define PWRC_BIT_IDLE 0
`define PWRC_BIT_POWERDOWN 1
`define PWRC_BIT_FLAG_LOW 2
`define PWRC_BIT_FLAG_HIGH 3

// ****************************************************************
// Field positions of the configuration and status registers
// ****************************************************************
`define PWRC_BIT_ADC_IDLE 0
`define PWRC_STAT_STATE_LSB 0
`define PWRC_STAT_STATE_MSB 2
`define PWRC_STAT_ADC_IDLE 3
`define PWRC_STAT_RAM_OK 4

// ****************************************************************
// Reset values
// ****************************************************************
`define PWRC_RST_POWER_CONTROL 8'h00
`define PWRC_RST_CONFIG 8'h00
`define PWRC_RESET_VECTOR 16'h0000

// ****************************************************************
// Timing counts in clock cycles
// ****************************************************************
`define PWRC_KBD_WAKE_CLKS 11'h400
`define PWRC_INT_RESET_CLKS 11'h018
`define PWRC_TAKEOVER_CLKS 11'h004

`endif

// >>> hdl/pwrc_wait_cnt.v
// Down counter used for wake and reset delays of the power-mode controller
module pwrc_wait_cnt #(
  parameter W = 11,
  parameter [W-1:0] RST_VAL = 11'h004
) (
  // Clock and reset
  input wire clk_sys,
  input wire clr_n,
  input wire ce,
  // Control
  input wire load,
  input wire [W-1:0] load_val,
  // Status
  output wire zero
);

  reg [W-1:0] cnt_ff;
  reg [W-1:0] nxt_cnt;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always @* begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != {W{1'b0}}) begin
      nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys or negedge clr_n) begin
    if (!clr_n) begin
      cnt_ff <= RST_VAL;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign zero = (cnt_ff == {W{1'b0}});

endmodule // pwrc_wait_cnt

// >>> test/pwrc_core_model.sv
// Behavioural core and interrupt controller facing the power-mode controller
module pwrc_core_model (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Controller side
  input wire cpu_clk_en_ff,
  input wire wake_irq_ff,
  input wire resume_load_ff,
  input wire [15:0] resume_addr_ff,
  // Bench side
  input wire irq_req,
  output logic irq_pending,
  output logic [15:0] core_next_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pc_ff;
  assign core_next_pc = pc_ff + 16'h0001;
  // Fetch runs on the CPU clock only; no port or external RAM write follows an entry
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) pc_ff <= 16'h0000;
    else if (resume_load_ff) pc_ff <= resume_addr_ff;
    else if (cpu_clk_en_ff) pc_ff <= pc_ff + 16'h0001;
  end
  // Pending level held until service entry
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) irq_pending <= 1'b0;
    else if (wake_irq_ff) irq_pending <= 1'b0;
    else if (irq_req) irq_pending <= 1'b1;
  end
endmodule // pwrc_core_model

// >>> test/pwrc_props.sv
// Assertion checker for the power-mode controller ports
module pwrc_props #(
  parameter int KBD_WAKE_CLKS = 16
) (
  // Clock and resets
  input wire clk_sys,
  input wire reset_n,
  input wire rst_pin,
  input wire ce,
  // Inputs
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire irq_pending,
  input wire ext_irq_a_n,
  input wire ext_irq_a_en,
  input wire ext_irq_b_n,
  input wire ext_irq_b_en,
  input wire [7:0] keyboard_wake_inputs,
  input wire kbd_wake_en,
  // Outputs
  input wire cpu_clk_en_ff,
  input wire periph_clk_en_ff,
  input wire osc_en_ff,
  input wire ram_access_en_ff,
  input wire sfr_reset_ff,
  input wire wake_irq_ff,
  input wire resume_load_ff,
  input wire [15:0] resume_addr_ff,
  input wire idle_request_bit_ff,
  input wire powerdown_request_bit_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // Resume is seen one sample after the counter reaches zero
  localparam int KBD_TAIL = KBD_WAKE_CLKS - 7;
  wire pd = powerdown_request_bit_ff;
  wire idle_request_bit = idle_request_bit_ff;
  wire cpu = cpu_clk_en_ff;
  wire run = cpu && ram_access_en_ff && !sfr_reset_ff && !idle_request_bit && !pd;
  wire ctl_wr = reg_wr && reg_addr == 8'h00 && run && ce;
  wire ext_low = (ext_irq_a_en && !ext_irq_a_n) || (ext_irq_b_en && !ext_irq_b_n);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n || rst_pin);
  sequence s_kbd_wake;
    pd && !ext_low && kbd_wake_en && |keyboard_wake_inputs;
  endsequence
  sequence s_kbd_resume;
    !cpu ##1 cpu && wake_irq_ff;
  endsequence
  a_idle_entry: assert property (ctl_wr && reg_wdata[1:0] == 2'b01 |=> idle_request_bit && !cpu && periph_clk_en_ff)
    else $error("idle entry wrong");
  a_pd_entry: assert property (ctl_wr && reg_wdata[1] |=> pd && !cpu && !osc_en_ff && !periph_clk_en_ff)
    else $error("power-down entry wrong");
  a_ext_wake: assert property (pd && ext_low |=> !pd && osc_en_ff && periph_clk_en_ff && !cpu)
    else $error("external wake wrong");
  a_ext_hold: assert property (!cpu && !idle_request_bit && !pd && !sfr_reset_ff && ext_low |=> !cpu)
    else $error("resumed with wake input held");
  a_idle_wake: assert property (idle_request_bit && irq_pending |=> !idle_request_bit && cpu && wake_irq_ff && resume_load_ff)
    else $error("idle wake wrong");
  a_kbd_delay: assert property (s_kbd_wake |=> !cpu [*8] ##KBD_TAIL s_kbd_resume)
    else $error("keyboard wake delay wrong");
  a_reset_seq: assert property ($rose(sfr_reset_ff) |=> sfr_reset_ff [*2] ##[1:4]
    ($fell(sfr_reset_ff) && ram_access_en_ff && resume_load_ff && resume_addr_ff == 16'h0000))
    else $error("internal reset sequence wrong");
  a_rst_clear: assert property (disable iff (!reset_n) rst_pin |-> !idle_request_bit && !pd && cpu && osc_en_ff)
    else $error("reset pin did not clear mode");
  a_rst_takeover: assert property ($fell(rst_pin) |-> cpu && !ram_access_en_ff && !sfr_reset_ff)
    else $error("takeover phase wrong");
  a_ce_freeze: assert property (!ce |=> $stable(idle_request_bit) && $stable(pd) && $stable(cpu) && $stable(resume_load_ff)) // ce
    else $error("state moved with clock enable low");
endmodule // pwrc_props

bind pwrc_idle_powerdown pwrc_props #(.KBD_WAKE_CLKS(KBD_WAKE_CLKS)) pwrc_props_inst (
  .clk_sys, .reset_n, .rst_pin, .ce, .reg_addr, .reg_wdata, .reg_wr, .irq_pending, .ext_irq_a_n, .ext_irq_a_en,
  .ext_irq_b_n, .ext_irq_b_en, .keyboard_wake_inputs, .kbd_wake_en, .cpu_clk_en_ff, .periph_clk_en_ff,
  .osc_en_ff, .ram_access_en_ff, .sfr_reset_ff, .wake_irq_ff, .resume_load_ff, .resume_addr_ff,
  .idle_request_bit_ff, .powerdown_request_bit_ff);

// >>> test/tb_top.sv
// Self-checking bench of the power-mode controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, rst_pin, reg_wr, reg_rd, adc_done, irq_req, irq_pending, rd_d;
  logic ext_irq_a_n, ext_irq_a_en, ext_irq_b_n, ext_irq_b_en, kbd_wake_en, ce;
  logic cpu_clk_en_ff, periph_clk_en_ff, osc_en_ff, ram_access_en_ff, sfr_reset_ff;
  logic wake_irq_ff, resume_load_ff, idle_request_bit_ff, powerdown_request_bit_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, keyboard_wake_inputs, flags;
  logic [15:0] core_next_pc, resume_addr_ff, pc_snap;
  logic [31:0] seed = 32'hA63728CD;
  logic [7:0] exp_rd[$];
  logic [16:0] exp_wk[$];
  int error_cnt = 0;
  int checks = 0;
  pwrc_idle_powerdown #(.KBD_WAKE_CLKS(11'd16), .INT_RESET_CLKS(11'd4), .TAKEOVER_CLKS(11'd2))
  pwrc_idle_powerdown_inst (.clk_sys, .reset_n, .ce, .rst_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .irq_pending, .adc_done, .ext_irq_a_n, .ext_irq_a_en, .ext_irq_b_n, .ext_irq_b_en,
    .keyboard_wake_inputs, .kbd_wake_en, .core_next_pc, .cpu_clk_en_ff, .periph_clk_en_ff, .osc_en_ff,
    .ram_access_en_ff, .sfr_reset_ff, .wake_irq_ff, .resume_load_ff, .resume_addr_ff, .idle_request_bit_ff,
    .powerdown_request_bit_ff);
  pwrc_core_model pwrc_core_model_inst (.clk_sys, .reset_n, .cpu_clk_en_ff, .wake_irq_ff, .resume_load_ff,
    .resume_addr_ff, .irq_req, .irq_pending, .core_next_pc);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ****
  // Tasks
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp(input string nm, input logic [16:0] e, input logic [16:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    #1 pc_snap = core_next_pc;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_wake(input int lim);
    int n;
    n = 0;
    while (resume_load_ff !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    cmp("wake_seen", 17'h00001, {16'h0000, n < lim});
    @(posedge clk_sys);
  endtask
  task automatic end_of_test();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Result watcher: read data and resume notes in order
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) cmp("rdata", {9'h000, exp_rd.pop_front()}, {9'h000, reg_rdata_ff});
    if (resume_load_ff === 1'b1) cmp("resume", exp_wk.size() ? exp_wk.pop_front() : 17'bx, {wake_irq_ff, resume_addr_ff});
  end
  initial begin
    #60us;
    error_cnt++;
    end_of_test();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {reset_n, rst_pin, reg_wr, reg_rd, adc_done, irq_req, kbd_wake_en, ext_irq_b_en} = 8'h00;
    {ext_irq_a_n, ext_irq_b_n, ext_irq_a_en} = 3'b111;
    ce = 1'b1;
    {reg_addr, reg_wdata, keyboard_wake_inputs} = 24'h000000;
    exp_wk.push_back(17'h00000);
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    wait_wake(40);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h08, 8'h10);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      flags = seed[7:0] & 8'h0C;
      wr(8'h00, flags);
      rd(8'h00, flags);
    end
    ce <= 1'b0;
    wr(8'h00, flags | 8'h01);
    ce <= 1'b1;
    rd(8'h00, flags);
    wr(8'h00, flags | 8'h01);
    exp_wk.push_back({1'b1, pc_snap});
    adc_done <= 1'b1;
    @(posedge clk_sys);
    adc_done <= 1'b0;
    rd(8'h00, flags | 8'h01);
    irq_req <= 1'b1;
    @(posedge clk_sys);
    irq_req <= 1'b0;
    wait_wake(20);
    wr(8'h04, 8'h01);
    wr(8'h00, flags | 8'h01);
    exp_wk.push_back({1'b0, pc_snap});
    adc_done <= 1'b1;
    @(posedge clk_sys);
    adc_done <= 1'b0;
    wait_wake(20);
    wr(8'h04, 8'h00);
    for (int k = 0; k < 2; k++) begin
      ext_irq_a_en <= (k == 0);
      ext_irq_b_en <= (k == 1);
      wr(8'h00, flags | 8'h02);
      exp_wk.push_back({1'b1, pc_snap});
      {ext_irq_a_n, ext_irq_b_n} <= k ? 2'b01 : 2'b10;
      rd(8'h00, flags | 8'h02);
      {ext_irq_a_n, ext_irq_b_n} <= 2'b00;
      repeat (6) @(posedge clk_sys);
      {ext_irq_a_n, ext_irq_b_n} <= 2'b11;
      wait_wake(20);
      rd(8'h00, flags);
    end
    wr(8'h00, flags | 8'h02);
    exp_wk.push_back({1'b1, pc_snap});
    seed = xs(seed);
    keyboard_wake_inputs <= seed[7:0] | 8'h01;
    rd(8'h00, flags | 8'h02);
    kbd_wake_en <= 1'b1;
    wait_wake(40);
    kbd_wake_en <= 1'b0;
    for (int m = 1; m < 3; m++) begin
      wr(8'h00, flags | m[7:0]);
      exp_wk.push_back(17'h00000);
      rst_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst_pin <= 1'b0;
      wait_wake(40);
      rd(8'h00, 8'h00);
    end
    end_of_test();
  end
endmodule // tb_top
